// ### qpc_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
  input  wire logic sys_clk,
  output var  logic phase_a_in,
  output var  logic phase_b_in,
  output var  logic index_in
);
  // quadrature state 0=00, 1=A, 2=AB, 3=B; forward walks upward
  logic [1:0] st;

  initial begin
    st = 2'h0;
    phase_a_in = 1'b0;
    phase_b_in = 1'b0;
    index_in = 1'b0;
  end

  // gap sets how slow the shaft turns; only a gap of 0 clocks merges edges
  task automatic step(input logic fwd, input int n, input int gap);
    repeat (n) begin
      st = fwd ? st + 2'h1 : st - 2'h1;
      phase_a_in <= st[1] ^ st[0];
      phase_b_in <= st[1];
      repeat (gap) @(posedge sys_clk);
    end
  endtask

  // a real encoder marks the index only with both phases low
  task automatic mark_index();
    if (st == 2'h0) begin
      index_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      index_in <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### qpc_pkg.sv
`default_nettype none
package qpc_pkg;
  // printed register offsets are indices; byte address is index times four
  localparam logic [9:0]  QPC_CTRL_IDX = 10'h122;
  localparam logic [9:0]  QPC_FILT_IDX = 10'h124;
  localparam logic [9:0]  QPC_POS_IDX  = 10'h126;
  localparam logic [9:0]  QPC_MAX_IDX  = 10'h128;
  localparam logic [11:0] QPC_CTRL_ADDR = {QPC_CTRL_IDX, 2'h0};
  localparam logic [11:0] QPC_FILT_ADDR = {QPC_FILT_IDX, 2'h0};
  localparam logic [11:0] QPC_POS_ADDR  = {QPC_POS_IDX, 2'h0};
  localparam logic [11:0] QPC_MAX_ADDR  = {QPC_MAX_IDX, 2'h0};

  // decoder control register fields
  localparam int QPC_ERR_BIT   = 15;
  localparam int QPC_INDEX_BIT = 12;
  localparam int QPC_DIR_BIT   = 11;
  localparam int QPC_MODE_LSB  = 8;
  localparam int QPC_RSTEN_BIT = 2;
  // filter control register fields
  localparam int QPC_MATCH_LSB = 9;
  localparam int QPC_EVOFF_BIT = 8;

  // mode field bits and codes
  localparam int QPC_MODE_ON_BIT  = 2;
  localparam int QPC_MODE_X4_BIT  = 1;
  localparam int QPC_MODE_MAX_BIT = 0;
  localparam logic [2:0] QPC_MODE_X2_INDEX = 3'h4;
  localparam logic [2:0] QPC_MODE_X4_INDEX = 3'h6;

  // values after reset, and the down-count error limit
  localparam logic [2:0]  QPC_MODE_RESET  = 3'h0;
  localparam logic [1:0]  QPC_MATCH_RESET = 2'h0;
  localparam logic [15:0] QPC_POS_RESET   = 16'h0000;
  localparam logic [15:0] QPC_MAX_RESET   = 16'hFFFF;
  localparam logic [15:0] QPC_DOWN_LIMIT  = 16'hFFFF;
endpackage
`default_nettype wire

// ### qpc_position_counter.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qpc_position_counter
  import qpc_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  phase_a_in,
  input  wire logic                  phase_b_in,
  input  wire logic                  index_in,
  output var  logic                  count_direction,
  output var  logic                  count_error_event,
  output var  logic                  index_event
);

  if (ADDR_WIDTH < 12) begin : g_width_check
    $error("ADDR_WIDTH must be at least 12");
  end

  function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a,
                                    input logic [11:0]           r);
    addr_hit = (a == ADDR_WIDTH'(r));
  endfunction

  function automatic logic index_matches(input logic       four_edge,
                                         input logic [1:0] sel,
                                         input logic       a,
                                         input logic       b);
    if (four_edge) begin
      index_matches = (b == sel[1]) && (a == sel[0]);
    end else begin
      index_matches = ((sel[1] ? b : a) == sel[0]);
    end
  endfunction

  // input synchronisers; stage 3 serves edge detection and the direction compare
  logic a_s1, a_s2, a_s3;
  logic b_s1, b_s2, b_s3;
  logic i_s1, i_s2;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_s3 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_s3 <= 1'b0;
      i_s1 <= 1'b0;
      i_s2 <= 1'b0;
    end else begin
      a_s1 <= phase_a_in;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= phase_b_in;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
      i_s1 <= index_in;
      i_s2 <= i_s1;
    end
  end

  // register and decoder state
  logic [15:0] position_counter;
  logic [15:0] maximum_count;
  logic [2:0]  decoder_mode_field;
  logic        index_reset_enable;
  logic        count_error_flag;
  logic [1:0]  index_match_field;
  logic        count_error_irq_disable;
  logic        index_hit_q;

  logic [15:0] next_position_counter;
  logic [15:0] next_maximum_count;
  logic [2:0]  next_decoder_mode_field;
  logic        next_index_reset_enable;
  logic        next_count_error_flag;
  logic [1:0]  next_index_match_field;
  logic        next_count_error_irq_disable;
  logic        next_index_hit_q;
  logic        next_count_direction;
  logic        next_count_error_event;
  logic        next_index_event;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic        a_edge;
  logic        b_edge;
  logic        decode_on;
  logic        four_edge;
  logic        max_mode;
  logic        check_mode;
  logic        count_pulse;
  logic        index_hit;
  logic        index_clear;
  logic        error_hit;
  logic [15:0] stepped;
  logic [15:0] error_limit;
  logic        wr_access;
  logic        rd_cycle;
  logic        wr_ctrl;
  logic        wr_filt;
  logic        wr_pos;
  logic        wr_max;
  logic        any_hit;
  logic [31:0] read_value;

  always_comb begin
    a_edge     = a_s2 ^ a_s3;
    b_edge     = b_s2 ^ b_s3;
    decode_on  = decoder_mode_field[QPC_MODE_ON_BIT];
    four_edge  = decoder_mode_field[QPC_MODE_X4_BIT];
    max_mode   = decoder_mode_field[QPC_MODE_MAX_BIT];
    check_mode = (decoder_mode_field == QPC_MODE_X2_INDEX) ||
                 (decoder_mode_field == QPC_MODE_X4_INDEX);
    // a step where both phases moved at once is ambiguous and dropped
    if (four_edge) begin
      count_pulse = decode_on && (a_edge ^ b_edge);
    end else begin
      count_pulse = decode_on && a_edge && !b_edge;
    end
    // new A against old B gives forward for A leading B
    if (decode_on && (a_edge ^ b_edge)) begin
      next_count_direction = a_s2 ^ b_s3;
    end else begin
      next_count_direction = count_direction;
    end

    if (next_count_direction) begin
      if (max_mode && (position_counter == maximum_count)) begin
        stepped = 16'h0000;
      end else begin
        stepped = position_counter + 16'h0001;
      end
      error_limit = maximum_count + 16'h0001;
    end else begin
      if (max_mode && (position_counter == 16'h0000)) begin
        stepped = maximum_count;
      end else begin
        stepped = position_counter - 16'h0001;
      end
      error_limit = QPC_DOWN_LIMIT;
    end
    error_hit = check_mode && count_pulse && (stepped == error_limit);

    // the index is expected while both phases are low; match field decides
    index_hit = check_mode && i_s2 &&
                index_matches(four_edge, index_match_field,
                              a_s2, b_s2);
    index_clear = index_hit && index_reset_enable;

    wr_access = psel && penable && pready && pwrite;
    rd_cycle  = psel && penable && !pready;
    wr_ctrl   = wr_access && addr_hit(paddr, QPC_CTRL_ADDR);
    wr_filt   = wr_access && addr_hit(paddr, QPC_FILT_ADDR);
    wr_pos    = wr_access && addr_hit(paddr, QPC_POS_ADDR);
    wr_max    = wr_access && addr_hit(paddr, QPC_MAX_ADDR);
    any_hit   = addr_hit(paddr, QPC_CTRL_ADDR) ||
                addr_hit(paddr, QPC_FILT_ADDR) ||
                addr_hit(paddr, QPC_POS_ADDR)  ||
                addr_hit(paddr, QPC_MAX_ADDR);

    // software write of the counter beats any hardware update that cycle
    if (wr_pos) begin
      next_position_counter = pwdata[15:0];
    end else if (index_clear) begin
      next_position_counter = QPC_POS_RESET;
    end else if (count_pulse) begin
      next_position_counter = stepped;
    end else begin
      next_position_counter = position_counter;
    end

    next_maximum_count           = wr_max ? pwdata[15:0] : maximum_count;
    next_decoder_mode_field      = decoder_mode_field;
    next_index_reset_enable      = index_reset_enable;
    next_count_error_flag        = count_error_flag;
    next_index_match_field       = index_match_field;
    next_count_error_irq_disable = count_error_irq_disable;
    if (wr_ctrl) begin
      next_decoder_mode_field = pwdata[QPC_MODE_LSB +: 3];
      next_index_reset_enable = pwdata[QPC_RSTEN_BIT];
      next_count_error_flag   = pwdata[QPC_ERR_BIT];
    end
    if (wr_filt) begin
      next_index_match_field       = pwdata[QPC_MATCH_LSB +: 2];
      next_count_error_irq_disable = pwdata[QPC_EVOFF_BIT];
    end
    // a detection in the clearing cycle must not be lost
    if (error_hit) begin
      next_count_error_flag = 1'b1;
    end

    next_count_error_event = error_hit && !count_error_irq_disable;
    next_index_hit_q       = index_hit;
    next_index_event       = index_hit && !index_hit_q;

    read_value = 32'h0000_0000;
    if (addr_hit(paddr, QPC_CTRL_ADDR)) begin
      read_value[QPC_ERR_BIT]       = count_error_flag;
      read_value[QPC_INDEX_BIT]     = i_s2;
      read_value[QPC_DIR_BIT]       = count_direction;
      read_value[QPC_MODE_LSB +: 3] = decoder_mode_field;
      read_value[QPC_RSTEN_BIT]     = index_reset_enable;
    end else if (addr_hit(paddr, QPC_FILT_ADDR)) begin
      read_value[QPC_MATCH_LSB +: 2] = index_match_field;
      read_value[QPC_EVOFF_BIT]      = count_error_irq_disable;
    end else if (addr_hit(paddr, QPC_POS_ADDR)) begin
      read_value[15:0] = position_counter;
    end else if (addr_hit(paddr, QPC_MAX_ADDR)) begin
      read_value[15:0] = maximum_count;
    end
    // one wait state: data and ready are registered off the first access
    next_pready  = rd_cycle;
    next_pslverr = rd_cycle && !any_hit;
    next_prdata  = (rd_cycle && !pwrite) ? read_value : prdata;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      position_counter        <= QPC_POS_RESET;
      maximum_count           <= QPC_MAX_RESET;
      decoder_mode_field      <= QPC_MODE_RESET;
      index_reset_enable      <= 1'b0;
      count_error_flag        <= 1'b0;
      index_match_field       <= QPC_MATCH_RESET;
      count_error_irq_disable <= 1'b0;
      index_hit_q             <= 1'b0;
      count_direction         <= 1'b0;
      count_error_event       <= 1'b0;
      index_event             <= 1'b0;
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end else begin
      position_counter        <= next_position_counter;
      maximum_count           <= next_maximum_count;
      decoder_mode_field      <= next_decoder_mode_field;
      index_reset_enable      <= next_index_reset_enable;
      count_error_flag        <= next_count_error_flag;
      index_match_field       <= next_index_match_field;
      count_error_irq_disable <= next_count_error_irq_disable;
      index_hit_q             <= next_index_hit_q;
      count_direction         <= next_count_direction;
      count_error_event       <= next_count_error_event;
      index_event             <= next_index_event;
      prdata                  <= next_prdata;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
    end
  end

  a_dir_forward: assert property (@(posedge sys_clk) disable iff (reset)
    (decode_on && a_edge && !b_edge && (a_s2 != b_s3)) |=> count_direction)
    else $error("forward step did not set direction");

  a_dir_reverse: assert property (@(posedge sys_clk) disable iff (reset)
    (decode_on && a_edge && !b_edge && (a_s2 == b_s3)) |=> !count_direction)
    else $error("reverse step did not clear direction");

  a_count_step: assert property (@(posedge sys_clk) disable iff (reset)
    (count_pulse && next_count_direction && !max_mode && !index_clear &&
     !wr_pos) |=> position_counter == $past(position_counter) + 16'h0001)
    else $error("counter did not step up by one");

  a_mode_off: assert property (@(posedge sys_clk) disable iff (reset)
    (!decode_on && !wr_pos) |=> $stable(position_counter))
    else $error("counter moved with decoding off");

  a_error_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (!check_mode && !wr_ctrl && !count_error_flag) |=> !count_error_flag)
    else $error("error flag set outside checked modes");

  a_error_set: assert property (@(posedge sys_clk) disable iff (reset)
    (check_mode && count_pulse && !next_count_direction &&
     position_counter == 16'h0000 && !wr_pos && !index_clear)
    |=> count_error_flag && position_counter == 16'hFFFF)
    else $error("underflow to all ones not flagged");

  a_irq_disable: assert property (@(posedge sys_clk) disable iff (reset)
    count_error_irq_disable |=> !count_error_event)
    else $error("error event despite disable");

  a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
    (error_hit && wr_ctrl && !pwdata[QPC_ERR_BIT]) |=> count_error_flag)
    else $error("software clear lost an error");

  a_index_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (index_clear && !wr_pos) |=> position_counter == 16'h0000)
    else $error("qualified index did not clear counter");

  a_max_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    (max_mode && count_pulse && next_count_direction && !wr_pos &&
     position_counter == maximum_count) |=> position_counter == 16'h0000)
    else $error("counter did not wrap at maximum");

  a_index_event: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(index_hit) |=> index_event ##1 !index_event)
    else $error("index event not a single pulse");

  a_sync_delay: assert property (@(posedge sys_clk) disable iff (reset)
    a_edge |-> $past(phase_a_in, 2) != $past(phase_a_in, 3))
    else $error("phase A edge seen without two stage delay");

endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qpc_pkg::*;
();
  logic        sys_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        phase_a_in;
  logic        phase_b_in;
  logic        index_in;
  logic        count_direction;
  logic        count_error_event;
  logic        index_event;
  logic [31:0] q;
  logic        q_err;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n_idx = 0;
  int          n_err = 0;

  qpc_position_counter i_dut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a_in(phase_a_in),
    .phase_b_in(phase_b_in), .index_in(index_in),
    .count_direction(count_direction),
    .count_error_event(count_error_event), .index_event(index_event));

  qpc_encoder_model i_enc (
    .sys_clk(sys_clk), .phase_a_in(phase_a_in),
    .phase_b_in(phase_b_in), .index_in(index_in));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // events are one-cycle pulses, so count them as they pass
  always @(posedge sys_clk) begin
    if (index_event === 1'b1) n_idx++;
    if (count_error_event === 1'b1) n_err++;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // idle edge first, so back-to-back calls never reassign psel at once
  task automatic xfer(input logic is_wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    q_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] cv(input logic [2:0] m, input logic r);
    cv = 32'h0;
    cv[QPC_MODE_LSB +: 3] = m;
    cv[QPC_RSTEN_BIT] = r;
  endfunction

  function automatic logic [31:0] fv(input logic [1:0] m, input logic c);
    fv = 32'h0;
    fv[QPC_MATCH_LSB +: 2] = m;
    fv[QPC_EVOFF_BIT] = c;
  endfunction

  task automatic t_regs();
    rd(QPC_CTRL_ADDR);
    check("ctrl rst", q, 32'h0);
    check("mapped ok", {31'h0, q_err}, 32'h0);
    i_enc.step(1'b1, 4, 8);
    rd(QPC_POS_ADDR);
    check("mode off", q, 32'h0);
    check("dir idle", {31'h0, count_direction}, 32'h0);
    rd(QPC_FILT_ADDR);
    check("filt rst", q, 32'h0);
    rd(QPC_MAX_ADDR);
    check("max rst", q, 32'h0000FFFF);
    wr(QPC_CTRL_ADDR, 32'h00000800);
    rd(QPC_CTRL_ADDR);
    check("dir ro", q, 32'h0);
    rd(12'h000);
    check("unmapped", {31'h0, q_err}, 32'h1);
  endtask

  task automatic t_x4();
    wr(QPC_CTRL_ADDR, cv(3'h7, 1'b0));
    i_enc.step(1'b1, 4, 8);
    rd(QPC_POS_ADDR);
    check("x4 up", q, 32'h4);
    check("dir up", {31'h0, count_direction}, 32'h1);
    rd(QPC_CTRL_ADDR);
    check("ctrl dir", q, cv(3'h7, 1'b0) | 32'h800);
    i_enc.step(1'b0, 8, 20);
    rd(QPC_POS_ADDR);
    check("x4 down", q, 32'hFFFC);
    check("dir down", {31'h0, count_direction}, 32'h0);
    wr(QPC_MAX_ADDR, 32'h5);
    wr(QPC_POS_ADDR, 32'h3);
    i_enc.step(1'b1, 4, 8);
    i_enc.mark_index();
    rd(QPC_POS_ADDR);
    check("max wrap", q, 32'h1);
    check("no idx ev", n_idx, 0);
    check("no err ev", n_err, 0);
  endtask

  task automatic t_x2();
    wr(QPC_CTRL_ADDR, cv(3'h5, 1'b0));
    wr(QPC_POS_ADDR, 32'h0);
    i_enc.step(1'b1, 4, 8);
    rd(QPC_POS_ADDR);
    check("x2 up", q, 32'h2);
    i_enc.step(1'b0, 2, 8);
    rd(QPC_POS_ADDR);
    check("x2 down", q, 32'h1);
    i_enc.step(1'b1, 2, 8);
  endtask

  task automatic t_index();
    logic [7:0] tb [9];
    int e;
    tb = '{8'hD3, 8'hD4, 8'hD8, 8'hC1, 8'h93, 8'h9B, 8'h9C, 8'h94, 8'hB0};
    // entry: mode, reset enable, match, clears, event
    foreach (tb[i]) begin
      wr(QPC_FILT_ADDR, fv(tb[i][3:2], 1'b0));
      wr(QPC_CTRL_ADDR, cv(tb[i][7:5], tb[i][4]));
      wr(QPC_POS_ADDR, 32'h0123);
      e = n_idx;
      i_enc.mark_index();
      rd(QPC_POS_ADDR);
      check("idx pos", q, tb[i][1] ? 32'h0 : 32'h0123);
      check("idx ev", n_idx - e, {31'h0, tb[i][0]});
    end
  endtask

  task automatic t_error();
    int e;
    wr(QPC_FILT_ADDR, fv(2'h0, 1'b0));
    wr(QPC_MAX_ADDR, 32'h10);
    wr(QPC_CTRL_ADDR, cv(3'h6, 1'b0));
    wr(QPC_POS_ADDR, 32'h10);
    e = n_err;
    i_enc.step(1'b1, 2, 8);
    rd(QPC_CTRL_ADDR);
    check("err up", {31'h0, q[15]}, 32'h1);
    check("err ev", n_err - e, 1);
    rd(QPC_POS_ADDR);
    check("past err", q, 32'h12);
    wr(QPC_CTRL_ADDR, cv(3'h6, 1'b0));
    rd(QPC_CTRL_ADDR);
    check("err clr", q, cv(3'h6, 1'b0) | 32'h800);
    wr(QPC_FILT_ADDR, fv(2'h0, 1'b1));
    wr(QPC_POS_ADDR, 32'h0);
    e = n_err;
    i_enc.step(1'b0, 1, 8);
    rd(QPC_CTRL_ADDR);
    check("err down", {31'h0, q[15]}, 32'h1);
    check("ev off", n_err - e, 0);
    i_enc.step(1'b1, 1, 8);
    wr(QPC_FILT_ADDR, fv(2'h0, 1'b0));
    wr(QPC_CTRL_ADDR, cv(3'h7, 1'b0));
    wr(QPC_POS_ADDR, 32'h0);
    e = n_err;
    i_enc.step(1'b0, 1, 8);
    rd(QPC_CTRL_ADDR);
    check("no err", {31'h0, q[15]}, 32'h0);
    check("no ev", n_err - e, 0);
    rd(QPC_POS_ADDR);
    check("under max", q, 32'h10);
  endtask

  // step one clock late so the error lands in the clearing write's cycle
  task automatic t_clear_race();
    wr(QPC_CTRL_ADDR, cv(3'h6, 1'b0));
    wr(QPC_POS_ADDR, 32'h0);
    fork
      begin
        @(posedge sys_clk);
        i_enc.step(1'b0, 1, 8);
      end
      wr(QPC_CTRL_ADDR, cv(3'h6, 1'b0));
    join
    rd(QPC_CTRL_ADDR);
    check("set wins", {31'h0, q[15]}, 32'h1);
    rd(QPC_POS_ADDR);
    check("race pos", q, 32'hFFFF);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_x4();
    t_x2();
    t_index();
    t_error();
    t_clear_race();
    finish_test();
  end
endmodule
`default_nettype wire
